// [fiber_mgmt_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Management controller model: an AXI4-Lite master with one transfer at a time.
module fiber_mgmt_host (
  // Clock
  input wire logic        aclk,
  // Write side
  output var logic [7:0]  s_axi_awaddr,
  output var logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  output var logic [31:0] s_axi_wdata,
  output var logic [3:0]  s_axi_wstrb,
  output var logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  output var logic        s_axi_bready,
  // Read side
  output var logic [7:0]  s_axi_araddr,
  output var logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  output var logic        s_axi_rready
);
  // Idle bus from time zero.
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // Lines are inverted on release, so a stale value is never taken for a live one.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
endmodule // fiber_mgmt_host
`default_nettype wire

// [fiber_status_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fiber_status_defines.vh"
// Watches the register bus and the status word beside the register block.
module fiber_status_chk (
  // Clock, reset and mode inputs
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        sgmii_mode,
  input wire logic [1:0]  fiber_mode,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  logic [7:0] ar_r;
  logic [2:0] sg_r;
  logic [1:0] md_r;
  logic [2:0] ms_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Saturating count of steady SGMII cycles, long enough to cover the synchroniser delay.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_r <= s_axi_araddr;
    end
    if (!sgmii_mode) begin
      sg_r <= 3'h0;
    end else if (sg_r != 3'h7) begin
      sg_r <= sg_r + 3'h1;
    end
  end
  // Count of steady mode cycles, so the decode is judged only once the mode has crossed.
  always_ff @(posedge aclk) begin
    md_r <= fiber_mode;
    if (!aresetn || fiber_mode != md_r) begin
      ms_r <= 3'h0;
    end else if (ms_r != 3'h7) begin
      ms_r <= ms_r + 3'h1;
    end
  end
  sequence st_rd;
    s_axi_rvalid && ar_r == `ADDR_FIBER_LINK_STATUS;
  endsequence
  sequence id_rd;
    s_axi_rvalid && ar_r == `ADDR_UNIQUE_ID_UPPER;
  endsequence
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data did not follow the address");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_write_answer: assert property (wr_taken |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  a_fixed_bits: assert property (st_rd |-> s_axi_rdata[31:16] == 16'h0000 &&
    !s_axi_rdata[15] && s_axi_rdata[12:9] == 4'h0 && s_axi_rdata[8] && s_axi_rdata[6] &&
    s_axi_rdata[0]) else $error("fixed status bit wrong");
  a_mode_bits: assert property (st_rd |-> s_axi_rdata[14] == s_axi_rdata[13] &&
    s_axi_rdata[3] != s_axi_rdata[14]) else $error("mode ability bits disagree");
  a_mode_decode: assert property (st_rd ##0 ms_r == 3'h7 |->
    s_axi_rdata[14] == (md_r == `MODE_100FX) && s_axi_rdata[3] == (md_r != `MODE_100FX))
    else $error("mode ability bits do not follow the mode");
  a_sgmii_fault: assert property (st_rd ##0 sg_r == 3'h7 |-> !s_axi_rdata[4])
    else $error("remote fault shown in SGMII mode");
  a_id_value: assert property (id_rd |-> s_axi_rresp == `RESP_OKAY &&
    s_axi_rdata == {16'h0000, `ID_UPPER_VALUE}) else $error("identifier wrong");
endmodule // fiber_status_chk
`default_nettype wire

// [fiber_status_defines.vh]
`ifndef FIBER_STATUS_DEFINES_VH
`define FIBER_STATUS_DEFINES_VH

// Register indices as printed; byte address is four times the index.
`define IDX_FIBER_LINK_STATUS  4'h1
`define IDX_UNIQUE_ID_UPPER    4'h2
`define IDX_INT_STATUS         4'h8
`define IDX_INT_MASK           4'h9
`define ADDR_FIBER_LINK_STATUS 8'h04
`define ADDR_UNIQUE_ID_UPPER   8'h08
`define ADDR_INT_STATUS        8'h20
`define ADDR_INT_MASK          8'h24

// Status register field positions.
`define BIT_T4              15
`define BIT_X_FD            14
`define BIT_X_HD            13
`define BIT_10_FD           12
`define BIT_10_HD           11
`define BIT_T2_FD           10
`define BIT_T2_HD           9
`define BIT_EXT_STATUS      8
`define BIT_PREAMBLE_SUPP   6
`define BIT_ANEG_DONE       5
`define BIT_REMOTE_FAULT    4
`define BIT_ANEG_ABILITY    3
`define BIT_LINK            2
`define BIT_EXT_CAP         0

// Fiber mode select encodings.
`define MODE_100FX          2'h0
`define MODE_1000X          2'h1

// Interrupt status bit positions and width.
`define INT_W               3
`define INT_LINK_DROP       0
`define INT_REMOTE_FAULT    1
`define INT_ANEG_DONE       2

// Reset values.
`define RST_INT_MASK        3'h0
`define RST_FLAG_LOW        1'b0

// Identifier value; arbitrary neutral value.
`define ID_UPPER_VALUE      16'h1234

// AXI responses.
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// [fiber_status_regs.v]
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "fiber_status_defines.vh"

module fiber_status_regs (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Fiber core status levels, asynchronous to aclk
  input  wire [1:0]  fiber_mode,
  input  wire        sgmii_mode,
  input  wire        link_up,
  input  wire        remote_fault,
  input  wire        aneg_complete,
  input  wire        aneg_bypass,
  input  wire        aneg_enabled,
  // Interrupt
  output reg         irq_r
);

  // Write channel states.
  localparam [2:0] WS_IDLE = 3'b001;
  localparam [2:0] WS_RESP = 3'b010;
  localparam [2:0] WS_HOLD = 3'b100;

  // Decode of a byte address into a one-hot register select.
  function [3:0] reg_sel;
    input [7:0] addr;
    begin
      case (addr)
        `ADDR_FIBER_LINK_STATUS: reg_sel = 4'h1;
        `ADDR_UNIQUE_ID_UPPER:   reg_sel = 4'h2;
        `ADDR_INT_STATUS:        reg_sel = 4'h4;
        `ADDR_INT_MASK:          reg_sel = 4'h8;
        default:                 reg_sel = 4'h0;
      endcase
    end
  endfunction

  // Synchronised levels, latched flags and decoded selects.
  wire [7:0]  sync_q;
  wire [1:0]  mode_s;
  wire        sgmii_s;
  wire        link_s;
  wire        rfault_s;
  wire        aneg_s;
  wire        link_flag;
  wire        rfault_flag;
  wire        status_rd;
  wire        mode_fx;
  wire [15:0] status_word;
  wire [`INT_W-1:0] int_event;
  wire [3:0]  wsel;
  wire [3:0]  rsel;
  wire        wr_fire;
  wire        rd_fire;

  // Write channel holding registers, interrupt state and edge history.
  reg  [2:0]  wstate_r;
  reg  [7:0]  awaddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         aw_have_r;
  reg         w_have_r;
  reg         aneg_done_r;
  reg         link_prev_r;
  reg         rfault_prev_r;
  reg  [`INT_W-1:0] int_status_r;
  reg  [`INT_W-1:0] int_mask_r;
  reg  [`INT_W-1:0] int_status_nxt;
  reg  [`INT_W-1:0] int_clr;

  // All core levels cross into aclk through two flops.
  sync2 #(.W(8)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({fiber_mode, sgmii_mode, link_up, remote_fault,
                aneg_complete, aneg_enabled, aneg_bypass}),
    .q_r     (sync_q)
  );
  assign mode_s   = sync_q[7:6];
  assign sgmii_s  = sync_q[5];
  assign link_s   = sync_q[4];
  assign rfault_s = sync_q[3];
  // The three negotiation levels are combined only after the crossing, so no
  // gate output that could glitch between them is ever sampled.
  assign aneg_s   = sync_q[2] & sync_q[1] & ~sync_q[0];

  // A read accepted at the status address releases both latched flags.
  assign rd_fire   = s_axi_arvalid & s_axi_arready;
  assign rsel      = reg_sel(s_axi_araddr);
  assign status_rd = rd_fire & rsel[0];

  latch_flag #(.LATCH_LOW(1)) u_link (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .cond     (link_s),
    .read_clr (status_rd),
    .flag_r   (link_flag)
  );

  latch_flag #(.LATCH_LOW(0)) u_rfault (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .cond     (rfault_s),
    .read_clr (status_rd),
    .flag_r   (rfault_flag)
  );

  // Negotiation-complete follows the core; bypass and disabled keep it clear.
  always @(posedge aclk) begin
    if (!aresetn)
      aneg_done_r <= 1'b0;
    else
      aneg_done_r <= aneg_s;
  end

  // Assemble the status word; mode-dependent bits decode from the mode field.
  assign mode_fx = (mode_s == `MODE_100FX);
  assign status_word[`BIT_T4]            = 1'b0;
  assign status_word[`BIT_X_FD]          = mode_fx;
  assign status_word[`BIT_X_HD]          = mode_fx;
  assign status_word[`BIT_10_FD]         = 1'b0;
  assign status_word[`BIT_10_HD]         = 1'b0;
  assign status_word[`BIT_T2_FD]         = 1'b0;
  assign status_word[`BIT_T2_HD]         = 1'b0;
  assign status_word[`BIT_EXT_STATUS]    = 1'b1;
  // Reserved positions always read zero.
  assign status_word[7]                  = 1'b0;
  assign status_word[`BIT_PREAMBLE_SUPP] = 1'b1;
  assign status_word[`BIT_ANEG_DONE]     = aneg_done_r;
  assign status_word[`BIT_REMOTE_FAULT]  = rfault_flag & ~sgmii_s;
  assign status_word[`BIT_ANEG_ABILITY]  = ~mode_fx;
  assign status_word[`BIT_LINK]          = link_flag;
  assign status_word[1]                  = 1'b0;
  assign status_word[`BIT_EXT_CAP]       = 1'b1;

  // Interrupt events: link drop, remote fault rise, negotiation finishing.
  assign int_event[`INT_LINK_DROP]    = link_prev_r & ~link_s;
  assign int_event[`INT_REMOTE_FAULT] = ~rfault_prev_r & rfault_s & ~sgmii_s;
  assign int_event[`INT_ANEG_DONE]    = ~aneg_done_r & aneg_s;

  // Write channel: address and data taken in either order, then a response.
  assign wr_fire = aw_have_r & w_have_r & (wstate_r == WS_IDLE);
  assign wsel    = reg_sel(awaddr_r);

  always @(posedge aclk) begin
    if (!aresetn) begin
      wstate_r      <= WS_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
    end else begin
      case (wstate_r)
        WS_IDLE: begin
          s_axi_awready <= ~aw_have_r & ~(s_axi_awvalid & s_axi_awready);
          s_axi_wready  <= ~w_have_r & ~(s_axi_wvalid & s_axi_wready);
          if (s_axi_awvalid & s_axi_awready) begin
            awaddr_r  <= s_axi_awaddr;
            aw_have_r <= 1'b1;
          end
          if (s_axi_wvalid & s_axi_wready) begin
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
            w_have_r <= 1'b1;
          end
          if (wr_fire) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            wstate_r      <= WS_RESP;
          end
        end
        WS_RESP: begin
          // Read-only registers accept the write silently; unmapped is an error.
          s_axi_bvalid <= 1'b1;
          s_axi_bresp  <= (wsel == 4'h0) ? `RESP_SLVERR : `RESP_OKAY;
          wstate_r     <= WS_HOLD;
        end
        WS_HOLD: begin
          // Dropping both holding flags reopens the address and data channels.
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            wstate_r     <= WS_IDLE;
          end
        end
        default: wstate_r <= WS_IDLE;
      endcase
    end
  end

  // Write-one-to-clear mask for interrupt status, applied in the response cycle.
  always @* begin
    int_clr = {`INT_W{1'b0}};
    if (wstate_r == WS_RESP && wsel[2] && wstrb_r[0])
      int_clr = wdata_r[`INT_W-1:0];
  end

  // A new event outranks a clear landing in the same cycle.
  always @* begin
    int_status_nxt = (int_status_r & ~int_clr) | int_event;
  end

  // Interrupt state, mask, edge history and the level output.
  // Edge history resets low, so a link already up after reset raises no event.
  // The mask acts on the level one cycle late, which a level interrupt tolerates.
  always @(posedge aclk) begin
    if (!aresetn) begin
      int_status_r  <= {`INT_W{1'b0}};
      int_mask_r    <= `RST_INT_MASK;
      link_prev_r   <= 1'b0;
      rfault_prev_r <= 1'b0;
      irq_r         <= 1'b0;
    end else begin
      int_status_r  <= int_status_nxt;
      link_prev_r   <= link_s;
      rfault_prev_r <= rfault_s;
      if (wstate_r == WS_RESP && wsel[3] && wstrb_r[0])
        int_mask_r <= wdata_r[`INT_W-1:0];
      irq_r <= |(int_status_nxt & int_mask_r);
    end
  end

  // Read channel: one read at a time, data one cycle after the address.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      // Ready rests low after a handshake and while data waits, so a second
      // address never overtakes unread data.
      s_axi_arready <= ~s_axi_rvalid & ~rd_fire & ~s_axi_arready;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (rsel)
          4'h1: s_axi_rdata <= {16'h0000, status_word};
          4'h2: s_axi_rdata <= {16'h0000, `ID_UPPER_VALUE};
          4'h4: s_axi_rdata <= {29'h0000_0000, int_status_r};
          4'h8: s_axi_rdata <= {29'h0000_0000, int_mask_r};
          // Unmapped addresses answer an error with zero data.
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // fiber_status_regs
`default_nettype wire

// [latch_flag.v]
`timescale 1ns/1ps
`default_nettype none
`include "fiber_status_defines.vh"

// One latched flag: high-latching or low-latching, released by a read.
module latch_flag #(
  parameter LATCH_LOW = 0
) (
  // Clock and reset
  input  wire aclk,
  input  wire aresetn,
  // Condition and read strobe
  input  wire cond,
  input  wire read_clr,
  // Latched value
  output reg  flag_r
);

  reg  flag_nxt;
  wire active;

  // The latched polarity is the condition's abnormal level.
  assign active = LATCH_LOW ? ~cond : cond;

  // A read returns the flag to the live value; an event in that cycle still wins.
  always @* begin
    if (LATCH_LOW != 0) begin
      if (active)
        flag_nxt = 1'b0;
      else if (read_clr)
        flag_nxt = cond;
      else
        flag_nxt = flag_r;
    end else begin
      if (active)
        flag_nxt = 1'b1;
      else if (read_clr)
        flag_nxt = cond;
      else
        flag_nxt = flag_r;
    end
  end

  // Both flags reset to zero.
  always @(posedge aclk) begin
    if (!aresetn)
      flag_r <= `RST_FLAG_LOW;
    else
      flag_r <= flag_nxt;
  end

endmodule // latch_flag
`default_nettype wire

// [sync2.v]
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a pin-level bus.
module sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // Asynchronous in, synchronous out
  input  wire [W-1:0] d,
  output reg  [W-1:0] q_r
);

  reg [W-1:0] meta_r;

  // The first stage feeds only the second one.
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= {W{1'b0}};
      q_r    <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

endmodule // sync2
`default_nettype wire

// [tb_fiber_status_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fiber_status_defines.vh"
module tb_fiber_status_regs;
  localparam logic [7:0] SA = `ADDR_FIBER_LINK_STATUS;
  localparam logic [7:0] ID = `ADDR_UNIQUE_ID_UPPER;
  localparam logic [7:0] IS = `ADDR_INT_STATUS;
  localparam logic [7:0] IM = `ADDR_INT_MASK;
  localparam logic [1:0] OK = `RESP_OKAY;
  localparam logic [1:0] ER = `RESP_SLVERR;
  logic        aclk, aresetn, sgmii_mode, link_up, remote_fault, irq_r;
  logic        aneg_complete, aneg_bypass, aneg_enabled;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  fiber_mode, s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb, rv;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ua;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [34:0] q[$];
  int          checks, miscompares;
  fiber_status_regs u_dut (.*);
  fiber_mgmt_host u_host (.*);
  // Free-running bus clock.
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic cmp(input logic [34:0] got, input logic [34:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Every answer on the bus is matched against the oldest expectation.
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      cmp({1'b0, s_axi_rresp, s_axi_rdata}, q.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      cmp({1'b1, s_axi_bresp, 32'h0000_0000}, q.pop_front());
    end
  end
  task automatic rd_chk(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
    q.push_back({1'b0, r, d});
    u_host.rd(a);
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q.push_back({1'b1, r, 32'h0000_0000});
    u_host.wr(a, d);
  endtask
  function automatic logic [31:0] sw(input logic [1:0] m, input logic an, rf, lk);
    sw = 32'h0000_0000;
    sw[14] = (m == 2'h0);
    sw[13] = (m == 2'h0);
    sw[8] = 1'b1;
    sw[6] = 1'b1;
    sw[5] = an;
    sw[4] = rf;
    sw[3] = (m != 2'h0);
    sw[2] = lk;
    sw[0] = 1'b1;
  endfunction
  // Two synchroniser flops plus the flag register, with one cycle spare.
  task automatic settle();
    repeat (4) @(posedge aclk);
  endtask
  task wrap_up;
    miscompares += q.size();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // A hang is cut short well past the expected run length.
  initial begin
    #500000;
    miscompares++;
    wrap_up;
  end
  initial begin
    seed = 32'ha3fd31dd;
    aresetn = 1'b0;
    fiber_mode = 2'h1;
    {sgmii_mode, link_up, remote_fault} = 3'b010;
    {aneg_complete, aneg_bypass, aneg_enabled} = 3'b001;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    rd_chk(SA, OK, sw(2'h1, 0, 0, 0));
    rd_chk(SA, OK, sw(2'h1, 0, 0, 1));
    for (int m = 0; m < 4; m++) begin
      fiber_mode <= m[1:0];
      settle();
      rd_chk(SA, OK, sw(m[1:0], 0, 0, 1));
    end
    fiber_mode <= 2'h1;
    link_up <= 1'b0;
    settle();
    link_up <= 1'b1;
    settle();
    rd_chk(SA, OK, sw(2'h1, 0, 0, 0));
    rd_chk(SA, OK, sw(2'h1, 0, 0, 1));
    remote_fault <= 1'b1;
    settle();
    remote_fault <= 1'b0;
    settle();
    rd_chk(SA, OK, sw(2'h1, 0, 1, 1));
    rd_chk(SA, OK, sw(2'h1, 0, 0, 1));
    remote_fault <= 1'b1;
    settle();
    rd_chk(SA, OK, sw(2'h1, 0, 1, 1));
    rd_chk(SA, OK, sw(2'h1, 0, 1, 1));
    sgmii_mode <= 1'b1;
    settle();
    remote_fault <= 1'b0;
    settle();
    rd_chk(SA, OK, sw(2'h1, 0, 0, 1));
    sgmii_mode <= 1'b0;
    aneg_complete <= 1'b1;
    settle();
    rd_chk(SA, OK, sw(2'h1, 1, 0, 1));
    aneg_bypass <= 1'b1;
    settle();
    rd_chk(SA, OK, sw(2'h1, 0, 0, 1));
    aneg_bypass <= 1'b0;
    aneg_enabled <= 1'b0;
    settle();
    rd_chk(SA, OK, sw(2'h1, 0, 0, 1));
    aneg_enabled <= 1'b1;
    link_up <= 1'b0;
    settle();
    link_up <= 1'b1;
    wr_chk(SA, $random(seed), OK);
    wr_chk(ID, $random(seed), OK);
    rd_chk(ID, OK, {16'h0000, `ID_UPPER_VALUE});
    rd_chk(SA, OK, sw(2'h1, 1, 0, 0));
    rv = $random(seed);
    ua = {2'h1, rv, 2'h0};
    rd_chk(ua, ER, 32'h0000_0000);
    wr_chk(ua, $random(seed), ER);
    rd_chk(IM, OK, {29'h0, `RST_INT_MASK});
    wr_chk(IS, 32'h0000_0007, OK);
    rd_chk(IS, OK, 32'h0000_0000);
    link_up <= 1'b0;
    settle();
    link_up <= 1'b1;
    settle();
    rd_chk(IS, OK, 32'h0000_0001);
    cmp(35'(irq_r), 35'h0);
    wr_chk(IM, 32'h0000_0001, OK);
    settle();
    cmp(35'(irq_r), 35'h1);
    wr_chk(IS, 32'h0000_0001, OK);
    settle();
    cmp(35'(irq_r), 35'h0);
    rd_chk(IS, OK, 32'h0000_0000);
    settle();
    wrap_up;
  end
endmodule // tb_fiber_status_regs
bind fiber_status_regs fiber_status_chk u_chk (.*);
`default_nettype wire
